// file: rtl/hph_handshake.sv
// Purpose: Handshake logic of a 16-bit asynchronous host port plus write FIFO
// Assumes: DMA side runs on sys_clk; host pins are asynchronous
// Notes:   Ready is active low; data bus enable is active low
`timescale 1ns/1ps

module hph_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  // Fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Drain side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0]   cnt;
    logic          in_ready;
    logic          out_valid;
  } hph_fifo_s_t;
  hph_fifo_s_t      f_reg, f_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push, pop;

  always_comb begin
    push   = in_valid & f_reg.in_ready;
    pop    = f_reg.out_valid & out_ready;
    f_next = f_reg;
    if (push) begin
      f_next.wptr = AW'(f_reg.wptr + 1'b1);
    end
    if (pop) begin
      f_next.rptr = AW'(f_reg.rptr + 1'b1);
    end
    f_next.cnt       = (AW+1)'(f_reg.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    f_next.in_ready  = f_next.cnt < (AW+1)'(DEPTH);
    f_next.out_valid = f_next.cnt != '0;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      f_reg          <= '0;
      f_reg.in_ready <= 1'b1;
    end else begin
      f_reg <= f_next;
    end
  end

  // Storage needs no reset; only entries below the count are visible
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[f_reg.wptr] <= in_data;
    end
  end

  assign in_ready  = f_reg.in_ready;
  assign out_valid = f_reg.out_valid;
  assign out_data  = mem[f_reg.rptr];
endmodule

module hph_handshake (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       reset,
  // Host pins
  input  wire logic                       host_chip_select_n,
  input  wire logic                       host_data_strobe_a,
  input  wire logic                       host_data_strobe_b,
  input  wire logic                       host_addr_strobe_n,
  input  wire logic [1:0]                 host_access_select,
  input  wire logic                       host_read_write,
  input  wire logic                       half_word_identifier,
  input  wire logic [hph_pkg::HALF_W-1:0] host_data_bus_in,
  output logic      [hph_pkg::HALF_W-1:0] host_data_bus_out,
  output logic                            host_data_bus_oe_n,
  output logic                            host_ready_n,
  // DMA read side
  output logic                            dma_fetch_req,
  output logic      [hph_pkg::WORD_W-1:0] dma_fetch_addr,
  input  wire logic                       dma_read_valid,
  input  wire logic [hph_pkg::WORD_W-1:0] dma_read_data,
  // DMA write side
  output logic                            dma_write_valid,
  output logic      [hph_pkg::WORD_W-1:0] dma_write_data,
  input  wire logic                       dma_write_ready,
  // Configuration view
  output logic      [hph_pkg::WORD_W-1:0] host_control_value,
  output logic      [hph_pkg::WORD_W-1:0] host_address_value
);
  import hph_pkg::*;

  typedef struct packed {
    logic [PIN_W-1:0]  s1;
    logic [PIN_W-1:0]  s2;
    logic              strobe_d;
    logic              as_d;
    hph_state_t        st;
    logic [1:0]        cnt;
    logic [3:0]        sel;
    logic              ready_n;
    logic              oe_n;
    logic [HALF_W-1:0] dout;
    logic [WORD_W-1:0] rd_word;
    logic [WORD_W-1:0] addr;
    logic [WORD_W-1:0] ctrl;
    logic [HALF_W-1:0] lo;
    logic              pending;
    logic              prefetched;
    logic              fetch_req;
    logic              push_v;
    logic [WORD_W-1:0] push_d;
  } hph_core_s_t;

  hph_core_s_t r_reg, r_next;
  logic        strobe_n, cs_n, as_n, fall, rise, push_rdy, is_data, is_read;
  logic [3:0]  sel_now;
  logic [HALF_W-1:0] din;

  function automatic logic sel_is_data(input logic [1:0] s);
    return (s == SEL_DATA_INC) || (s == SEL_DATA_FIXED);
  endfunction

  always_comb begin
    r_next = r_reg;
    // First stage feeds only the second
    r_next.s1 = {host_data_bus_in, host_chip_select_n, host_data_strobe_a, host_data_strobe_b,
                 host_addr_strobe_n, host_access_select, host_read_write, half_word_identifier};
    r_next.s2 = r_reg.s1;
    cs_n     = r_reg.s2[PIN_CS];
    as_n     = r_reg.s2[PIN_AS];
    din      = r_reg.s2[PIN_DATA_LSB +: HALF_W];
    strobe_n = cs_n | ~(r_reg.s2[PIN_DS_A] ^ r_reg.s2[PIN_DS_B]);
    r_next.strobe_d = strobe_n;
    r_next.as_d     = as_n;
    fall     = r_reg.strobe_d & ~strobe_n;
    rise     = ~r_reg.strobe_d & strobe_n;
    // Address strobe latches the select group; else the strobe fall does
    sel_now  = {r_reg.s2[PIN_SEL_LSB +: 2], r_reg.s2[PIN_RW], r_reg.s2[PIN_HW]};
    if (r_reg.as_d & ~as_n) begin
      r_next.sel = sel_now;
    end
    if (fall && as_n) begin
      r_next.sel = sel_now;
    end
    is_data  = sel_is_data(r_next.sel[3:2]);
    is_read  = r_next.sel[1];
    r_next.fetch_req = 1'b0;
    if (r_reg.push_v & push_rdy) begin
      r_next.push_v  = 1'b0;
      r_next.pending = 1'b0;
    end
    if (dma_read_valid) begin
      r_next.rd_word    = dma_read_data;
      r_next.prefetched = 1'b1;
      if (!r_reg.push_v) begin
        r_next.pending = 1'b0;
      end
    end
    case (r_reg.st)
      ST_IDLE: begin
        if (fall) begin
          if (is_data && is_read && !r_next.sel[0] && !r_next.prefetched) begin
            r_next.fetch_req = 1'b1;
            r_next.st        = ST_FETCH;
          end else if (is_read) begin
            r_next.st   = is_data ? ST_PRESENT : ST_ACTIVE;
            r_next.cnt  = DATA_LEAD_CYC;
            r_next.oe_n = 1'b0;
            case (r_next.sel[3:2])
              SEL_CONTROL: r_next.dout = r_next.sel[0] ? r_reg.ctrl[31:16] : r_reg.ctrl[15:0];
              SEL_ADDRESS: r_next.dout = r_next.sel[0] ? r_reg.addr[31:16] : r_reg.addr[15:0];
              default:     r_next.dout = r_next.sel[0] ? r_next.rd_word[31:16]
                                                       : r_next.rd_word[15:0];
            endcase
          end else begin
            r_next.st = ST_ACTIVE;
          end
        end
      end
      ST_FETCH: begin
        if (dma_read_valid) begin
          r_next.st   = ST_PRESENT;
          r_next.cnt  = DATA_LEAD_CYC;
          r_next.oe_n = 1'b0;
          r_next.dout = dma_read_data[15:0];
        end
      end
      ST_PRESENT: begin
        // Data leads the ready fall by the counted cycles
        r_next.cnt = 2'(r_reg.cnt - 1'b1);
        if (r_reg.cnt == 2'h1) begin
          r_next.st = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (rise) begin
          r_next.st   = ST_IDLE;
          r_next.oe_n = 1'b1;
          // Second-half write or data read leaves the held word stale
          r_next.prefetched = r_next.prefetched & ~(r_reg.sel[0] & (~is_read | is_data));
          if (!is_read) begin
            if (!r_reg.sel[0]) begin
              r_next.lo = din;
            end
            case (r_reg.sel[3:2])
              SEL_CONTROL: r_next.ctrl = r_reg.sel[0] ? {din, r_reg.lo} : r_reg.ctrl;
              SEL_ADDRESS: r_next.addr = r_reg.sel[0] ? {din, r_reg.lo} : r_reg.addr;
              default: begin
                if (r_reg.sel[0]) begin
                  r_next.push_v  = 1'b1;
                  r_next.push_d  = {din, r_reg.lo};
                  r_next.pending = 1'b1;
                  if (r_reg.sel[3:2] == SEL_DATA_INC) begin
                    r_next.addr = r_reg.addr + ADDR_STEP;
                  end
                end
              end
            endcase
          end else if (r_reg.sel[3:2] == SEL_DATA_INC && r_reg.sel[0]) begin
            // Prefetch the next word so the following read is quick
            r_next.addr       = r_reg.addr + ADDR_STEP;
            r_next.prefetched = 1'b0;
            r_next.fetch_req  = 1'b1;
            r_next.pending    = 1'b1;
          end
        end
      end
      default: r_next.st = ST_IDLE;
    endcase
    // Ready: gated by chip select; only data traffic can hold it high
    r_next.ready_n = ~cs_n & (r_next.pending | r_next.st == ST_FETCH
                              | r_next.st == ST_PRESENT);
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      r_reg          <= '0;
      r_reg.s1       <= PIN_RESET;
      r_reg.s2       <= PIN_RESET;
      r_reg.strobe_d <= 1'b1;
      r_reg.as_d     <= 1'b1;
      r_reg.st       <= ST_IDLE;
      r_reg.oe_n     <= 1'b1;
      r_reg.addr     <= WORD_RESET;
      r_reg.ctrl     <= WORD_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  // Full FIFO stalls the push, which keeps the port busy
  hph_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .in_valid  (r_reg.push_v),
    .in_data   (r_reg.push_d),
    .in_ready  (push_rdy),
    .out_valid (dma_write_valid),
    .out_data  (dma_write_data),
    .out_ready (dma_write_ready)
  );

  assign host_data_bus_out  = r_reg.dout;
  assign host_data_bus_oe_n = r_reg.oe_n;
  assign host_ready_n       = r_reg.ready_n;
  assign dma_fetch_req      = r_reg.fetch_req;
  assign dma_fetch_addr     = r_reg.addr;
  assign host_control_value = r_reg.ctrl;
  assign host_address_value = r_reg.addr;

  a_ready_cs_gate: assert property (@(posedge sys_clk) disable iff (reset)
    r_reg.s2[PIN_CS] |=> !host_ready_n) else $error("ready high while deselected");
  a_busy_at_select: assert property (@(posedge sys_clk) disable iff (reset)
    (!r_reg.s2[PIN_CS] && r_next.pending) |=> host_ready_n) else $error("busy not shown");
  a_fetch_on_fall: assert property (@(posedge sys_clk) disable iff (reset)
    (r_reg.st == ST_IDLE && r_next.st == ST_FETCH) |=> dma_fetch_req)
    else $error("fetch not issued");
  a_wait_for_load: assert property (@(posedge sys_clk) disable iff (reset)
    (r_reg.st == ST_FETCH && !r_reg.s2[PIN_CS]) |=> host_ready_n) else $error("ready early");
  a_data_lead: assert property (@(posedge sys_clk) disable iff (reset)
    (r_reg.st == ST_FETCH && dma_read_valid) |=> !host_data_bus_oe_n ##1 host_ready_n
    ##1 $fell(host_ready_n) || r_reg.s2[PIN_CS]) else $error("data lead wrong");
  a_write_busy: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(r_reg.push_v) |-> r_reg.pending) else $error("write not pending");
  a_other_low: assert property (@(posedge sys_clk) disable iff (reset)
    (r_reg.st == ST_ACTIVE && !r_reg.pending && !sel_is_data(r_reg.sel[3:2]))
    |=> !host_ready_n) else $error("ready rose on register access");
  a_strobe_form: assert property (@(posedge sys_clk) disable iff (reset)
    (r_reg.s2[PIN_CS] && r_reg.st == ST_IDLE) |=> r_reg.st == ST_IDLE)
    else $error("access without select");
endmodule

// file: rtl/hph_pkg.sv
// Purpose: Constants and types for the host port handshake block
// Assumes: 100 MHz sys_clk, host pins asynchronous to it
// Notes:   Pin vector layout and select codes are shared with the bench
// Behaviour
// - Internal access strobe low only while chip select low and data strobes differ.
// - Ready is held low whenever chip select is high.
// - Ready goes high at chip select fall while earlier transfer still completes.
// - First half-word data read strobe fall issues a fetch to the DMA engine unless the word is already prefetched.
// - Data read keeps ready high until the DMA word is loaded.
// - Ready rises at strobe rise after second half of data write or autoincrement read.
// - Other accesses leave ready low after the strobe rises.
// - Control and address register accesses never affect ready.
// - Read data is valid two clock cycles before ready falls.
// - After address strobe falls, ready may rise if the port is busy.
package hph_pkg;
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          DATA_LEAD_NS   = 2 * CLK_PERIOD_NS;
  localparam logic [1:0]  DATA_LEAD_CYC  = 2'(DATA_LEAD_NS / CLK_PERIOD_NS);
  localparam int          FIFO_DEPTH     = 16;
  localparam int          WORD_W         = 32;
  localparam int          HALF_W         = 16;
  localparam logic [31:0] ADDR_STEP      = 32'h0000_0004;
  localparam logic [31:0] WORD_RESET     = 32'h0000_0000;
  // Access select codes
  localparam logic [1:0]  SEL_CONTROL    = 2'h0;
  localparam logic [1:0]  SEL_DATA_INC   = 2'h1;
  localparam logic [1:0]  SEL_ADDRESS    = 2'h2;
  localparam logic [1:0]  SEL_DATA_FIXED = 2'h3;
  // Bit positions of the sampled pin vector
  localparam int          PIN_W          = 24;
  localparam int          PIN_DATA_LSB   = 8;
  localparam int          PIN_CS         = 7;
  localparam int          PIN_DS_A       = 6;
  localparam int          PIN_DS_B       = 5;
  localparam int          PIN_AS         = 4;
  localparam int          PIN_SEL_LSB    = 2;
  localparam int          PIN_RW         = 1;
  localparam int          PIN_HW         = 0;
  localparam logic [PIN_W-1:0] PIN_RESET = 24'h00_00F0;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0001,
    ST_FETCH   = 4'b0010,
    ST_PRESENT = 4'b0100,
    ST_ACTIVE  = 4'b1000
  } hph_state_t;
endpackage

// file: test/hph_host_model.sv
// Purpose: Behavioural host that moves half-words through the port pins
// Assumes: Pins change only at the falling edge of sys_clk
// Notes:   Strobes alternate so both data strobes take turns
`timescale 1ns/1ps

module hph_host_model (
  // Clock
  input  wire logic  sys_clk,
  // Pins toward the port
  output logic       host_chip_select_n,
  output logic       host_data_strobe_a,
  output logic       host_data_strobe_b,
  output logic       host_addr_strobe_n,
  output logic [1:0] host_access_select,
  output logic       host_read_write,
  output logic       half_word_identifier,
  output logic [15:0] host_data_bus_in,
  input  wire logic  host_ready_n,
  // Marks for the bench
  output logic       read_taken,
  output logic       timed_out
);
  initial begin
    {host_chip_select_n, host_addr_strobe_n, host_read_write} = 3'h7;
    {host_data_strobe_a, host_data_strobe_b, half_word_identifier} = 3'h0;
    {host_access_select, host_data_bus_in, read_taken, timed_out} = '0;
  end

  task automatic chip(input logic v);
    @(negedge sys_clk) host_chip_select_n = v;
    repeat (4) @(negedge sys_clk);
  endtask

  task automatic access(input logic [1:0] sel, input logic rw, input logic hw,
                        input logic [15:0] d, input logic use_as);
    int n;
    @(negedge sys_clk);
    host_access_select = sel;
    host_read_write = rw;
    half_word_identifier = hw;
    // Released bus keeps moving so a stale value never looks valid
    host_data_bus_in = rw ? ~host_data_bus_in : d;
    if (use_as) @(negedge sys_clk) host_addr_strobe_n = 1'b0;
    @(negedge sys_clk) host_data_strobe_a = ~host_data_strobe_a;
    @(negedge sys_clk) host_addr_strobe_n = 1'b1;
    repeat (6) @(negedge sys_clk);
    n = 0;
    while (host_ready_n !== 1'b0 && n < 400) begin
      @(negedge sys_clk);
      n++;
    end
    if (n == 400) timed_out = 1'b1;
    if (rw) @(negedge sys_clk) read_taken = 1'b1;
    @(negedge sys_clk);
    read_taken = 1'b0;
    host_data_strobe_b = ~host_data_strobe_b;
    repeat (5) @(negedge sys_clk);
  endtask
endmodule

// file: test/tb_top.sv
// Purpose: Self-checking bench for the host port handshake
// Assumes: Design ready and data follow the hand-over timing
// Notes:   Expectations queued by drivers, compared by the monitor
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_top;
  import hph_pkg::*;
  logic sys_clk, reset, host_chip_select_n, host_data_strobe_a, host_data_strobe_b;
  logic host_addr_strobe_n, host_read_write, half_word_identifier, host_data_bus_oe_n;
  logic host_ready_n, dma_fetch_req, dma_read_valid, dma_write_valid, dma_write_ready;
  logic read_taken, timed_out, rdy_q;
  logic [1:0]  host_access_select;
  logic [15:0] host_data_bus_in, host_data_bus_out, dout_q;
  logic [31:0] dma_fetch_addr, dma_read_data, dma_write_data, host_address_value, w, a;
  logic [31:0] host_control_value, fa;
  logic [31:0] exp_fetch[$], exp_push[$], exp_rd[$];
  int err_count = 0, comparisons = 0, lead = 0;

  hph_handshake i_hph_handshake (.sys_clk, .reset, .host_chip_select_n, .host_data_strobe_a,
    .host_data_strobe_b, .host_addr_strobe_n, .host_access_select, .host_read_write,
    .half_word_identifier, .host_data_bus_in, .host_data_bus_out, .host_data_bus_oe_n,
    .host_ready_n, .dma_fetch_req, .dma_fetch_addr, .dma_read_valid, .dma_read_data,
    .dma_write_valid, .dma_write_data, .dma_write_ready, .host_control_value,
    .host_address_value);
  hph_host_model i_host (.sys_clk, .host_chip_select_n, .host_data_strobe_a,
    .host_data_strobe_b, .host_addr_strobe_n, .host_access_select, .host_read_write,
    .half_word_identifier, .host_data_bus_in, .host_ready_n, .read_taken, .timed_out);

  function automatic logic [31:0] mem_word(input logic [31:0] x);
    return {x[15:0], ~x[15:0]} ^ 32'h1357_9bdf;
  endfunction

  task automatic take(ref logic [31:0] q[$], input logic [31:0] got);
    if (q.size() == 0) `CHK(got, 32'hdead_beef)
    else `CHK(got, q.pop_front())
  endtask

  task automatic wr_word(input logic [1:0] s, input logic [31:0] v, input logic as);
    i_host.access(s, 1'b0, 1'b0, v[15:0], as);
    i_host.access(s, 1'b0, 1'b1, v[31:16], as);
  endtask

  task automatic rd_word(input logic [1:0] s, input logic [31:0] v, input logic as);
    exp_rd.push_back({16'h0000, v[15:0]});
    exp_rd.push_back({16'h0000, v[31:16]});
    i_host.access(s, 1'b1, 1'b0, 16'h0000, as);
    i_host.access(s, 1'b1, 1'b1, 16'h0000, as);
  endtask

  task automatic tally_and_finish();
    $display("counts: comparisons=%0d mismatches=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Memory behind the fetch requests, answering after a random delay
  initial begin
    {dma_read_valid, dma_read_data} = '0;
    forever begin
      @(posedge sys_clk iff dma_fetch_req === 1'b1);
      fa = dma_fetch_addr;
      repeat ($urandom_range(1, 6)) @(negedge sys_clk);
      dma_read_data = mem_word(fa);
      dma_read_valid = 1'b1;
      @(negedge sys_clk) dma_read_valid = 1'b0;
      dma_read_data = ~dma_read_data;
    end
  end

  always @(posedge sys_clk) begin
    if (dma_fetch_req === 1'b1) take(exp_fetch, dma_fetch_addr);
    if (dma_write_valid === 1'b1 && dma_write_ready === 1'b1)
      take(exp_push, dma_write_data);
    if (read_taken === 1'b1) take(exp_rd, {16'h0000, host_data_bus_out});
    if (rdy_q === 1'b1 && host_ready_n === 1'b0 && host_data_bus_oe_n === 1'b0)
      `CHK(lead > 0, 1'b1)
    lead <= (host_data_bus_oe_n === 1'b0 && host_data_bus_out === dout_q) ? lead + 1 : 0;
    rdy_q <= host_ready_n;
    dout_q <= host_data_bus_out;
  end

  initial begin
    repeat (50000) @(posedge sys_clk);
    err_count++;
    tally_and_finish();
  end

  initial begin
    {reset, dma_write_ready} = 2'h2;
    void'($urandom(32'h47c1));
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk) reset = 1'b0;
    repeat (5) @(negedge sys_clk);
    i_host.chip(1'b0);
    w = $urandom;
    wr_word(SEL_CONTROL, w, 1'b1);
    `CHK(host_ready_n, 1'b0)
    `CHK(host_control_value, w)
    rd_word(SEL_CONTROL, w, 1'b0);
    w = $urandom & 32'hffff_fffc;
    wr_word(SEL_ADDRESS, w, 1'b0);
    `CHK(host_ready_n, 1'b0)
    `CHK(host_address_value, w)
    rd_word(SEL_ADDRESS, w, 1'b1);
    $display("test registers done");
    i_host.chip(1'b1);
    wr_word(SEL_ADDRESS, ~w, 1'b0);
    `CHK(host_ready_n, 1'b0)
    `CHK(host_address_value, w)
    $display("test deselected done");
    i_host.chip(1'b0);
    exp_fetch.push_back(w);
    exp_fetch.push_back(w + ADDR_STEP);
    rd_word(SEL_DATA_INC, mem_word(w), 1'b0);
    repeat (20) @(negedge sys_clk);
    `CHK(host_address_value, w + ADDR_STEP)
    a = $urandom & 32'hffff_fffc;
    wr_word(SEL_ADDRESS, a, 1'b0);
    exp_fetch.push_back(a);
    rd_word(SEL_DATA_FIXED, mem_word(a), 1'b1);
    $display("test data reads done");
    for (int i = 0; i <= FIFO_DEPTH; i++) begin
      w = $urandom;
      exp_push.push_back(w);
      wr_word(i[0] ? SEL_DATA_FIXED : SEL_DATA_INC, w, i[1]);
    end
    `CHK(host_ready_n, 1'b1)
    i_host.chip(1'b1);
    `CHK(host_ready_n, 1'b0)
    i_host.chip(1'b0);
    `CHK(host_ready_n, 1'b1)
    for (int n = 0; n < 2000 && exp_push.size() > 0; n++)
      @(negedge sys_clk) dma_write_ready = 1'($urandom_range(0, 1));
    @(negedge sys_clk) dma_write_ready = 1'b1;
    repeat (6) @(negedge sys_clk);
    `CHK(exp_push.size(), 0)
    `CHK(host_ready_n, 1'b0)
    `CHK(timed_out, 1'b0)
    `CHK(exp_fetch.size() + exp_rd.size(), 0)
    $display("test write buffer done");
    tally_and_finish();
  end
endmodule
